// *** src/pums_cfg_if.sv ***
// interface: emulation loader to sequencer link
`timescale 1ns/1ps
interface pums_cfg_if;
   logic load_en;
   logic load_done;
   logic [31:0] bits_seen;

   modport loader (input load_en, output load_done, output bits_seen);
   modport seq (output load_en, input load_done, input bits_seen);
endinterface : pums_cfg_if

// *** src/pums_cfg_loader.sv ***
// module: configuration bitstream counter for emulation mode
`timescale 1ns/1ps
module pums_cfg_loader #(
   parameter int unsigned STREAM_BITS = pums_pkg::BITSTREAM_BITS
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // serial stream
   input wire logic cfg_bit_valid_in,
   // sequencer side
   pums_cfg_if.loader cfg
);
   initial
   begin
      if (STREAM_BITS < 1)
         $error("stream length must be at least one bit");
   end

   typedef struct packed {
      logic [31:0] cnt;
      logic done;
   } pums_ld_t;

   pums_ld_t q, d;

   // count accepted bits; data bits are consumed, content not kept
   always_comb
   begin
      d = q;
      if (cfg.load_en && !q.done && cfg_bit_valid_in)
      begin
         d.cnt = q.cnt + 32'h1;
         if (q.cnt == 32'(STREAM_BITS - 1))
            d.done = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         q <= '0;
      else
         q <= d;
   end

   assign cfg.load_done = q.done;
   assign cfg.bits_seen = q.cnt;
endmodule : pums_cfg_loader

// *** src/pums_pkg.sv ***
// package: constants and types for the power-up mode sequencer
package pums_pkg;

   // --------------------------------------------------------------------
   // power-up modes
   // --------------------------------------------------------------------
   typedef enum logic [1:0] {
      PUMS_MODE_INSTANT = 2'h0,
      PUMS_MODE_DELAYED = 2'h1,
      PUMS_MODE_EMULATE = 2'h2
   } pums_mode_t;

   // --------------------------------------------------------------------
   // timing
   // --------------------------------------------------------------------
   localparam int unsigned HOLD_TIME_MS = 50;
   localparam int unsigned CLK_FREQ_HZ = 20000000;
   localparam int unsigned MS_PER_S = 1000;
   // least time: whole cycles, rounded down, at least one cycle
   localparam int unsigned HOLD_CYCLES_RAW =
      (HOLD_TIME_MS * (CLK_FREQ_HZ / MS_PER_S));
   localparam int unsigned HOLD_CYCLES =
      (HOLD_CYCLES_RAW < 1) ? 1 : HOLD_CYCLES_RAW;
   // cycles spent in initialization before user release
   localparam int unsigned INIT_CYCLES = 4;
   // default bitstream length in bits
   localparam int unsigned BITSTREAM_BITS = 1024;

   // --------------------------------------------------------------------
   // sequencer states, one-hot
   // --------------------------------------------------------------------
   typedef enum logic [4:0] {
      PUMS_ST_POR  = 5'h01,
      PUMS_ST_HOLD = 5'h02,
      PUMS_ST_LOAD = 5'h04,
      PUMS_ST_INIT = 5'h08,
      PUMS_ST_RUN  = 5'h10
   } pums_state_t;

endpackage : pums_pkg

// *** src/pums_sequencer.sv ***
// module: power-up mode sequencer top
`timescale 1ns/1ps
module pums_sequencer #(
   parameter pums_pkg::pums_mode_t MODE = pums_pkg::PUMS_MODE_INSTANT,
   parameter int unsigned HOLD_CYCLES = pums_pkg::HOLD_CYCLES,
   parameter int unsigned STREAM_BITS = pums_pkg::BITSTREAM_BITS,
   parameter bit INIT_DONE_EN = 1'b0
) (
   // clock and power-on reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // emulation stream
   input wire logic cfg_bit_valid_in,
   input wire logic cfg_bit_in,
   // completion line, open drain
   input wire logic config_complete_line_in,
   output logic config_complete_line_out,
   output logic config_complete_line_oe_out,
   // init-done line, open drain
   input wire logic init_done_line_in,
   output logic init_done_line_out,
   output logic init_done_line_oe_out,
   // user logic
   output logic user_reset_n_out,
   output logic user_ready_out
);
   // --------------------------------------------------------------------
   // elaboration checks
   // --------------------------------------------------------------------
   initial
   begin
      if (HOLD_CYCLES < 1 || STREAM_BITS < 1)
         $error("hold and stream counts must be at least one");
   end

   typedef struct packed {
      pums_pkg::pums_state_t st;
      logic [31:0] cnt;
      logic cc_oe;
      logic id_oe;
      logic rst_n;
      logic ready;
   } pums_seq_t;

   pums_seq_t q, d;
   pums_cfg_if cfg ();
   logic unused_bits;

   assign unused_bits = cfg_bit_in ^ config_complete_line_in ^
      init_done_line_in ^ (|cfg.bits_seen);

   pums_cfg_loader #(.STREAM_BITS(STREAM_BITS)) u_loader (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .cfg_bit_valid_in(cfg_bit_valid_in),
      .cfg(cfg.loader)
   );

   // --------------------------------------------------------------------
   // sequencer; mode is a constant so the path is fixed at build
   // --------------------------------------------------------------------
   always_comb
   begin
      d = q;
      unique case (q.st)
         pums_pkg::PUMS_ST_POR:
         begin
            // first edge after reset release picks the path
            d.cnt = '0;
            if (MODE == pums_pkg::PUMS_MODE_INSTANT)
            begin
               d.st = pums_pkg::PUMS_ST_RUN;
               d.cc_oe = 1'b0;
            end
            else if (MODE == pums_pkg::PUMS_MODE_DELAYED)
            begin
               d.st = pums_pkg::PUMS_ST_HOLD;
               d.cc_oe = 1'b1;
            end
            else
            begin
               d.st = pums_pkg::PUMS_ST_LOAD;
               d.cc_oe = 1'b1;
               d.id_oe = INIT_DONE_EN;
            end
         end
         pums_pkg::PUMS_ST_HOLD:
         begin
            d.cnt = q.cnt + 32'h1;
            if (q.cnt == 32'(HOLD_CYCLES - 1))
            begin
               d.st = pums_pkg::PUMS_ST_RUN;
               d.cc_oe = 1'b0;
            end
         end
         pums_pkg::PUMS_ST_LOAD:
         begin
            if (cfg.load_done)
            begin
               d.st = pums_pkg::PUMS_ST_INIT;
               d.cc_oe = 1'b0;
               d.cnt = '0;
            end
         end
         pums_pkg::PUMS_ST_INIT:
         begin
            d.cnt = q.cnt + 32'h1;
            if (q.cnt == 32'(pums_pkg::INIT_CYCLES - 1))
            begin
               d.st = pums_pkg::PUMS_ST_RUN;
               d.id_oe = 1'b0;
            end
         end
         pums_pkg::PUMS_ST_RUN:
         begin
            // user leaves reset only after every line is released
            d.rst_n = 1'b1;
            d.ready = 1'b1;
         end
         default:
            d.st = pums_pkg::PUMS_ST_POR;
      endcase
   end

   // power-on reset clears all state, floats both open-drain lines and holds user reset low
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q <= '0;
         q.st <= pums_pkg::PUMS_ST_POR;
      end
      else
         q <= d;
   end

   assign cfg.load_en = (q.st == pums_pkg::PUMS_ST_LOAD);

   // open drain: only ever pull low
   assign config_complete_line_out = 1'b0;
   assign config_complete_line_oe_out = q.cc_oe;
   assign init_done_line_out = 1'b0;
   assign init_done_line_oe_out = q.id_oe;
   assign user_reset_n_out = q.rst_n;
   assign user_ready_out = q.ready;
endmodule : pums_sequencer

// *** tb/pums_board.sv ***
// model: board pull-ups and the configuration host
`timescale 1ns/1ps
module pums_board (
   // pull-down enables from the device
   input wire logic cc_oe_in,
   input wire logic id_oe_in,
   // resolved line levels
   output logic cc_line_out,
   output logic id_line_out,
   output logic host_ready_out
);
   // open drain: the pull-up wins unless the device pulls low
   assign cc_line_out = !cc_oe_in;
   assign id_line_out = !id_oe_in;
   // host starts traffic only once both lines are high
   assign host_ready_out = cc_line_out && id_line_out;
endmodule : pums_board

// *** tb/pums_seq_props.sv ***
// checker: timing properties of the power-up mode sequencer
`timescale 1ns/1ps
module pums_seq_props #(
   parameter pums_pkg::pums_mode_t MODE = pums_pkg::PUMS_MODE_INSTANT,
   parameter int unsigned HOLD_CYCLES = 10,
   parameter int unsigned STREAM_BITS = 8
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // watched ports
   input wire logic cfg_bit_valid_in,
   input wire logic config_complete_line_out,
   input wire logic config_complete_line_oe_out,
   input wire logic init_done_line_out,
   input wire logic init_done_line_oe_out,
   input wire logic user_reset_n_out,
   input wire logic user_ready_out
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   localparam bit EMU = (MODE == pums_pkg::PUMS_MODE_EMULATE);
   localparam bit DLY = (MODE == pums_pkg::PUMS_MODE_DELAYED);
   // hold cycles or accepted bits while the line is pulled low
   always_comb cnt_d = !config_complete_line_oe_out ? 32'h0 :
      cnt_q + (EMU ? 32'(cfg_bit_valid_in) : 32'h1);
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
      if (!rst_n_in) cnt_q <= 32'h0;
      else cnt_q <= cnt_d;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   drive_low_a: assert property (!config_complete_line_out)
      else $error("completion line driven high");
   id_low_a: assert property (!init_done_line_out)
      else $error("init-done line driven high");
   inst_no_hold_a: assert property (!DLY && !EMU |->
      !config_complete_line_oe_out) else $error("instant mode held line");
   inst_fast_a: assert property (!DLY && !EMU && $rose(rst_n_in)
      |-> ##2 user_ready_out) else $error("instant mode late");
   hold_len_a: assert property ($fell(config_complete_line_oe_out)
      |-> cnt_q == (DLY ? HOLD_CYCLES : STREAM_BITS))
      else $error("wrong hold or bit count");
   dly_release_a: assert property (DLY &&
      $fell(config_complete_line_oe_out) |=> user_ready_out)
      else $error("delayed release late");
   emu_init_a: assert property (EMU && $fell(config_complete_line_oe_out)
      |-> !user_ready_out [*5] ##1 user_ready_out)
      else $error("initialization length wrong");
   ready_gate_a: assert property (user_ready_out |->
      !config_complete_line_oe_out && !init_done_line_oe_out)
      else $error("ready while a line is held");
   ready_pair_a: assert property (user_ready_out == user_reset_n_out)
      else $error("reset and ready disagree");
   ready_keep_a: assert property (user_ready_out |=> user_ready_out)
      else $error("ready dropped");
   cover property ($fell(config_complete_line_oe_out));
   cover property ($rose(user_ready_out));
   cover property ($fell(init_done_line_oe_out));
endmodule : pums_seq_props
bind pums_sequencer pums_seq_props #(.MODE(MODE),
   .HOLD_CYCLES(HOLD_CYCLES), .STREAM_BITS(STREAM_BITS)) pums_seq_props_i (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
   .cfg_bit_valid_in(cfg_bit_valid_in),
   .config_complete_line_out(config_complete_line_out),
   .config_complete_line_oe_out(config_complete_line_oe_out),
   .init_done_line_out(init_done_line_out),
   .init_done_line_oe_out(init_done_line_oe_out),
   .user_reset_n_out(user_reset_n_out), .user_ready_out(user_ready_out));

// *** tb/pums_sequencer_bench.sv ***
// bench: the sequencer built in all three power-up modes side by side
`timescale 1ns/1ps
module pums_sequencer_bench;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic vld = 1'b0;
   logic bit_v = 1'b0;
   logic cc_line, id_line, host_rdy;
   logic [2:0] cc_oe, id_oe, urst, rdy;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   // bit 0 instant, bit 1 delayed, bit 2 emulation with init-done
   for (genvar g = 0; g < 3; g++)
   begin : g_mode
      pums_sequencer #(.MODE(pums_pkg::pums_mode_t'(g)), .HOLD_CYCLES(10),
         .STREAM_BITS(8), .INIT_DONE_EN(g == 2)) pums_sequencer_i (
         .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
         .cfg_bit_valid_in(vld), .cfg_bit_in(bit_v),
         .config_complete_line_in(g == 2 ? cc_line : 1'b1),
         .config_complete_line_out(), .config_complete_line_oe_out(cc_oe[g]),
         .init_done_line_in(g == 2 ? id_line : 1'b1), .init_done_line_out(),
         .init_done_line_oe_out(id_oe[g]), .user_reset_n_out(urst[g]),
         .user_ready_out(rdy[g]));
   end
   pums_board pums_board_i (.cc_oe_in(cc_oe[2]), .id_oe_in(id_oe[2]),
      .cc_line_out(cc_line), .id_line_out(id_line),
      .host_ready_out(host_rdy));
   initial
   begin
      forever
      begin
         #25 sys_clk_in = ~sys_clk_in;
      end
   end
   // a hang ends the run as a failure
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 500)
      begin
         failures++;
         end_sim();
      end
   end
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : step
   task automatic reset_seq;
      rst_n_in = 1'b0;
      step(6);
      chk(cc_oe | id_oe, 3'h0);
      chk(rdy | urst, 3'h0);
      rst_n_in = 1'b1;
   endtask : reset_seq
   // full walk: eight back-to-back bits, delayed hold of ten cycles
   task automatic walk;
      step(1);
      chk(cc_oe, 3'h6);
      chk(id_oe, 3'h4);
      vld = 1'b1;
      step(1);
      chk(rdy, 3'h1);
      step(7);
      vld = 1'b0;
      // done is registered on the last bit's edge, so release is one later
      step(1);
      chk(cc_oe, 3'h2);
      step(1);
      chk(cc_oe, 3'h0);
      chk(rdy, 3'h1);
      step(1);
      chk(rdy & urst, 3'h3);
      step(2);
      chk(id_oe, 3'h0);
      chk(rdy, 3'h3);
      step(1);
      chk(rdy & urst, 3'h7);
      chk({2'h0, host_rdy}, 3'h1);
   endtask : walk
   task automatic t_modes;
      reset_seq();
      walk();
   endtask : t_modes
   // power lost mid-load and mid-hold: everything starts over
   task automatic t_abort;
      reset_seq();
      step(1);
      vld = 1'b1;
      step(4);
      vld = 1'b0;
      reset_seq();
      walk();
   endtask : t_abort
   task automatic end_sim;
      if (failures == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   initial
   begin
      @(negedge sys_clk_in);
      t_modes();
      t_abort();
      end_sim();
   end
endmodule : pums_sequencer_bench
